// File: hw/uafc_pkg.sv
// uafc_pkg: constants and types of the dual UART frame check and
// address filter; assumes an 8-bit register port and external ticks.
`default_nettype none

package uafc_pkg;

  localparam logic [1:0][7:0] OFS_CTRL  = {8'hC0, 8'h98};
  localparam logic [1:0][7:0] OFS_DATA  = {8'hC1, 8'h99};
  localparam logic [1:0][7:0] OFS_SLAVE_ADDRESS_BYTE = {8'hAA, 8'hA9};
  localparam logic [1:0][7:0] OFS_SLAVE_ADDRESS_MASK_BYTE = {8'hBA, 8'hB9};
  localparam logic [1:0][7:0] OFS_FCE   = {8'hBB, 8'h87};
  localparam logic [1:0][2:0] FCE_BIT   = {3'h3, 3'h6};
  localparam logic [7:0] OFS_IRQ_STAT = 8'hE0;
  localparam logic [7:0] OFS_IRQ_MASK = 8'hE1;

  localparam int CTRL_FE_SM0 = 7;
  localparam int CTRL_SM1    = 6;
  localparam int CTRL_SM2    = 5;
  localparam int CTRL_REN    = 4;
  localparam int CTRL_TB8    = 3;
  localparam int CTRL_RB8    = 2;
  localparam int CTRL_TI     = 1;
  localparam int CTRL_RI     = 0;

  localparam int IRQ_RX     = 0;
  localparam int IRQ_TX     = 1;
  localparam int IRQ_FE     = 2;
  localparam int IRQ_PER_CH = 3;

  localparam logic [7:0] ADDR_RST = 8'h00;
  localparam logic       TXD_IDLE = 1'b1;

  // 16x oversampling: last tick of a bit, last tick of half a bit
  localparam logic [3:0] BIT_LAST   = 4'hF;
  localparam logic [3:0] HALF_LAST  = 4'h7;
  localparam logic [3:0] SHIFT_LAST = 4'h7;
  localparam logic [3:0] TXN_MODE0  = 4'h8;
  localparam logic [3:0] TXN_8BIT   = 4'hA;
  localparam logic [3:0] TXN_9BIT   = 4'hB;

  typedef enum logic [1:0] {
    UAFC_SHIFT = 2'b00,
    UAFC_UART8 = 2'b01,
    UAFC_UART9F = 2'b10,
    UAFC_UART9V = 2'b11
  } uafc_mode_t;

  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_BITS  = 2'b10,
    RX_STOP  = 2'b11
  } uafc_rx_t;

  typedef struct packed {
    uafc_mode_t  mode;
    logic        fce;
    logic        sm2;
    logic        ren;
    logic        tb8;
    logic        rb8;
    logic        ti;
    logic        ri;
    logic        fe;
    logic [7:0]  rxBuf;
    logic [7:0]  slave_address_byte;
    logic [7:0]  slave_address_mask_byte;
    logic [1:0]  rxSync;
    uafc_rx_t    rxSt;
    logic [3:0]  rxTc;
    logic [3:0]  rxN;
    logic [8:0]  rxSh;
    logic        rxDlv;
    logic        txBusy;
    logic [3:0]  txN;
    logic [10:0] txSh;
    logic        txd;
  } uafc_chan_t;

  typedef struct packed {
    uafc_chan_t [1:0] ch;
    logic [5:0]       irqStat;
    logic [5:0]       irqMask;
    logic [7:0]       rdData;
  } uafc_state_t;

endpackage : uafc_pkg

`default_nettype wire

// File: hw/uafc_top.sv
// uafc_top: two identical UART channels with framing check and
// automatic address recognition; baud ticks come from outside on clock.
//
// The address-and-strobe port was left to the implementer.
`default_nettype none

module uafc_top
  import uafc_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWrData,
  input  wire logic       regWr,
  input  wire logic       regRd,
  output logic      [7:0] regRdData,
  input  wire logic [1:0] rxdPin,
  output logic      [1:0] txdPin,
  input  wire logic [1:0] rxTick,
  input  wire logic [1:0] txTick,
  input  wire logic [1:0] shiftTick,
  output logic            irq
);

  uafc_state_t s;
  uafc_state_t n;

  // observation of each frame decision, read by the checks below
  logic [1:0] dlvEv;
  logic [1:0] acceptEv;
  logic [1:0] matchEv;
  logic [1:0] ninthEv;
  logic [1:0] stopEv;
  logic [1:0] stopBad;
  logic [5:0] ev;

  // zero mask bits are don't-care in the address comparison; the broadcast one ignores bits zero in both address and mask
  function automatic logic addr_match(logic [7:0] a, logic [7:0] sa,
                                      logic [7:0] se);
    logic [7:0] bc;
    bc = sa | se;
    addr_match = (((a ^ sa) & se) == 8'h00)
               || (((a ^ bc) & bc) == 8'h00);
  endfunction

  always_comb begin
    logic [7:0] dData;
    logic       dNinth;
    logic       dlv;
    logic       md0;
    logic       sm2e;
    logic       line;
    logic       nb9;
    logic [8:0] sh;
    logic       acc;
    dData = 8'h00;
    dNinth = 1'b0;
    dlv = 1'b0;
    md0 = 1'b0;
    sm2e = 1'b0;
    line = 1'b1;
    nb9 = 1'b0;
    sh = 9'h000;
    acc = 1'b0;
    n = s;
    n.rdData = 8'h00;
    ev = 6'h00;
    dlvEv = 2'b00;
    acceptEv = 2'b00;
    matchEv = 2'b00;
    ninthEv = 2'b00;
    stopEv = 2'b00;
    stopBad = 2'b00;

    // both channels carry the same logic
    for (int c = 0; c < 2; c++) begin
      dlv = 1'b0;
      dData = 8'h00;
      dNinth = 1'b0;
      sh = s.ch[c].rxSh;
      line = s.ch[c].rxSync[1];
      md0 = (s.ch[c].mode == UAFC_SHIFT);
      nb9 = s.ch[c].mode[1];
      sm2e = s.ch[c].sm2 && !md0;

      // software side; hardware updates below override it
      if (regWr && regAddr == OFS_CTRL[c]) begin
        if (s.ch[c].fce)
          n.ch[c].fe = regWrData[CTRL_FE_SM0];
        else
          n.ch[c].mode[1] = regWrData[CTRL_FE_SM0];
        n.ch[c].mode[0] = regWrData[CTRL_SM1];
        n.ch[c].sm2 = regWrData[CTRL_SM2];
        n.ch[c].ren = regWrData[CTRL_REN];
        n.ch[c].tb8 = regWrData[CTRL_TB8];
        n.ch[c].rb8 = regWrData[CTRL_RB8];
        n.ch[c].ti = regWrData[CTRL_TI];
        n.ch[c].ri = regWrData[CTRL_RI];
      end else if (regWr && regAddr == OFS_SLAVE_ADDRESS_BYTE[c]) begin
        n.ch[c].slave_address_byte = regWrData;
      end else if (regWr && regAddr == OFS_SLAVE_ADDRESS_MASK_BYTE[c]) begin
        n.ch[c].slave_address_mask_byte = regWrData;
      end else if (regWr && regAddr == OFS_FCE[c]) begin
        n.ch[c].fce = regWrData[FCE_BIT[c]];
      end else if (regWr && regAddr == OFS_DATA[c]) begin
        // a write while the transmitter is busy is dropped
        if (!s.ch[c].txBusy) begin
          n.ch[c].txBusy = 1'b1;
          if (md0) begin
            n.ch[c].txSh = {3'b111, regWrData};
            n.ch[c].txN = TXN_MODE0;
          end else if (nb9) begin
            n.ch[c].txSh = {1'b1, s.ch[c].tb8, regWrData, 1'b0};
            n.ch[c].txN = TXN_9BIT;
          end else begin
            n.ch[c].txSh = {2'b11, regWrData, 1'b0};
            n.ch[c].txN = TXN_8BIT;
          end
        end
      end

      if (regRd && regAddr == OFS_CTRL[c]) begin
        n.rdData = {s.ch[c].fce ? s.ch[c].fe : s.ch[c].mode[1],
                    s.ch[c].mode[0], s.ch[c].sm2, s.ch[c].ren,
                    s.ch[c].tb8, s.ch[c].rb8, s.ch[c].ti, s.ch[c].ri};
      end else if (regRd && regAddr == OFS_DATA[c]) begin
        n.rdData = s.ch[c].rxBuf;
      end else if (regRd && regAddr == OFS_SLAVE_ADDRESS_BYTE[c]) begin
        n.rdData = s.ch[c].slave_address_byte;
      end else if (regRd && regAddr == OFS_SLAVE_ADDRESS_MASK_BYTE[c]) begin
        n.rdData = s.ch[c].slave_address_mask_byte;
      end else if (regRd && regAddr == OFS_FCE[c]) begin
        n.rdData = 8'h00;
        n.rdData[FCE_BIT[c]] = s.ch[c].fce;
      end

      // transmitter, on its own tick so rx and tx rates differ
      if (s.ch[c].txBusy && txTick[c]) begin
        if (s.ch[c].txN == 4'h0) begin
          n.ch[c].txBusy = 1'b0;
          n.ch[c].txd = TXD_IDLE;
          if (md0) begin
            n.ch[c].ti = 1'b1;
            ev[c*IRQ_PER_CH+IRQ_TX] = 1'b1;
          end
        end else begin
          n.ch[c].txd = s.ch[c].txSh[0];
          n.ch[c].txSh = {1'b1, s.ch[c].txSh[10:1]};
          n.ch[c].txN = s.ch[c].txN - 4'h1;
          // async: flag rises as the stop bit starts
          if (!md0 && s.ch[c].txN == 4'h1) begin
            n.ch[c].ti = 1'b1;
            ev[c*IRQ_PER_CH+IRQ_TX] = 1'b1;
          end
        end
      end

      // receiver; pin passes two flops, only the second is read
      n.ch[c].rxSync = {s.ch[c].rxSync[0], rxdPin[c]};
      if (md0) begin
        n.ch[c].rxSt = RX_IDLE;
        if (s.ch[c].ren && !s.ch[c].ri && shiftTick[c]) begin
          sh = {line, s.ch[c].rxSh[8:1]};
          n.ch[c].rxSh = sh;
          n.ch[c].rxN = s.ch[c].rxN + 4'h1;
          if (s.ch[c].rxN == SHIFT_LAST) begin
            n.ch[c].rxN = 4'h0;
            dlv = 1'b1;
            dData = sh[8:1];
          end
        end
      end else if (rxTick[c]) begin
        n.ch[c].rxTc = s.ch[c].rxTc + 4'h1;
        case (s.ch[c].rxSt)
          RX_IDLE: begin
            n.ch[c].rxTc = 4'h0;
            if (s.ch[c].ren && !line) n.ch[c].rxSt = RX_START;
          end
          RX_START: begin
            // a start bit that is high again at mid-bit is a glitch
            if (s.ch[c].rxTc == HALF_LAST) begin
              n.ch[c].rxTc = 4'h0;
              n.ch[c].rxN = 4'h0;
              n.ch[c].rxSt = line ? RX_IDLE : RX_BITS;
            end
          end
          RX_BITS: begin
            if (s.ch[c].rxTc == BIT_LAST) begin
              sh = {line, s.ch[c].rxSh[8:1]};
              n.ch[c].rxSh = sh;
              n.ch[c].rxN = s.ch[c].rxN + 4'h1;
              if (s.ch[c].rxN == (nb9 ? 4'h8 : 4'h7)) begin
                n.ch[c].rxSt = RX_STOP;
                n.ch[c].rxDlv = 1'b0;
                // early delivery at last data bit unless stop is needed
                if (!s.ch[c].fce && !(sm2e && !nb9)) begin
                  dlv = 1'b1;
                  dData = nb9 ? sh[7:0] : sh[8:1];
                  dNinth = nb9 ? sh[8] : 1'b0;
                end
              end
            end
          end
          RX_STOP: begin
            if (s.ch[c].rxTc == BIT_LAST) begin
              n.ch[c].rxSt = RX_IDLE;
              // leave the bit count clean so a later mode 0 shift
              // starts counting from zero
              n.ch[c].rxN = 4'h0;
              stopEv[c] = 1'b1;
              stopBad[c] = !line;
              if (s.ch[c].fce && !line) begin
                n.ch[c].fe = 1'b1;
                ev[c*IRQ_PER_CH+IRQ_FE] = 1'b1;
              end
              if (!nb9 && s.ch[c].rxDlv)
                n.ch[c].rb8 = line;
              if (s.ch[c].fce || (sm2e && !nb9)) begin
                dlv = 1'b1;
                dData = nb9 ? sh[7:0] : sh[8:1];
                dNinth = nb9 ? sh[8] : line;
              end
            end
          end
          default: n.ch[c].rxSt = RX_IDLE;
        endcase
      end

      // frame acceptance; a full buffer drops the frame
      if (dlv) begin
        dlvEv[c] = 1'b1;
        matchEv[c] = addr_match(dData, s.ch[c].slave_address_byte, s.ch[c].slave_address_mask_byte);
        ninthEv[c] = dNinth;
        acc = !s.ch[c].ri
            && (!sm2e || (dNinth && matchEv[c]));
        if (acc) begin
          acceptEv[c] = 1'b1;
          n.ch[c].rxBuf = dData;
          if (!md0) n.ch[c].rb8 = dNinth;
          n.ch[c].rxDlv = 1'b1;
          n.ch[c].ri = 1'b1;
          ev[c*IRQ_PER_CH+IRQ_RX] = 1'b1;
        end
      end
    end

    // status: write one clears, a same-cycle event wins
    if (regWr && regAddr == OFS_IRQ_STAT)
      n.irqStat = s.irqStat & ~regWrData[5:0];
    else if (regWr && regAddr == OFS_IRQ_MASK)
      n.irqMask = regWrData[5:0];
    n.irqStat = n.irqStat | ev;
    if (regRd && regAddr == OFS_IRQ_STAT)
      n.rdData = {2'b00, s.irqStat};
    else if (regRd && regAddr == OFS_IRQ_MASK)
      n.rdData = {2'b00, s.irqMask};
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s <= '0;
      for (int c = 0; c < 2; c++) begin
        s.ch[c].slave_address_byte <= ADDR_RST;
        s.ch[c].slave_address_mask_byte <= ADDR_RST;
        s.ch[c].txd <= TXD_IDLE;
        // synchroniser starts at the idle line level, no false start
        s.ch[c].rxSync <= 2'b11;
      end
    end else begin
      s <= n;
    end
  end

  assign regRdData = s.rdData;
  assign irq = |(s.irqStat & s.irqMask);
  generate
    for (genvar g = 0; g < 2; g++) begin : g_tx
      assign txdPin[g] = s.ch[g].txd;
    end
  endgenerate

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  generate
    for (genvar g = 0; g < 2; g++) begin : g_chk
      addr_filter_a: assert property (
        acceptEv[g] && s.ch[g].sm2 && s.ch[g].mode != UAFC_SHIFT
        |-> matchEv[g] && ninthEv[g])
        else $error("frame accepted without address match");
      ninth_gate_a: assert property (
        dlvEv[g] && !ninthEv[g] && s.ch[g].sm2 && s.ch[g].mode[1]
        |=> !$rose(s.ch[g].ri))
        else $error("data frame raised receive complete");
      mode1_stop_a: assert property (
        acceptEv[g] && s.ch[g].sm2 && s.ch[g].mode == UAFC_UART8
        |-> stopEv[g] && !stopBad[g])
        else $error("mode 1 address frame without valid stop");
      fe_set_a: assert property (
        stopEv[g] && stopBad[g] && s.ch[g].fce
        |=> s.ch[g].fe && s.irqStat[g*IRQ_PER_CH+IRQ_FE])
        else $error("bad stop bit did not set framing error");
      fe_sticky_a: assert property (
        s.ch[g].fe && !(regWr && regAddr == OFS_CTRL[g])
        |=> s.ch[g].fe)
        else $error("framing error cleared without write");
      fe_enable_a: assert property (
        $rose(s.ch[g].fe) && !$past(regWr)
        |-> $past(s.ch[g].fce) && $past(s.ch[g].mode) != UAFC_SHIFT)
        else $error("framing error set while checking off");
      ri_at_stop_a: assert property (
        dlvEv[g] && s.ch[g].fce && s.ch[g].mode != UAFC_SHIFT
        |-> stopEv[g])
        else $error("receive complete before stop bit");
      mode0_plain_a: assert property (
        dlvEv[g] && s.ch[g].mode == UAFC_SHIFT && !s.ch[g].ri
        |=> s.ch[g].ri ##1 s.ch[g].ri || $past(regWr))
        else $error("mode 0 frame filtered");
      reset_addr_a: assert property (
        $rose(rst_n) |-> s.ch[g].slave_address_byte == 8'h00 && s.ch[g].slave_address_mask_byte == 8'h00)
        else $error("address bytes not cleared by reset");
      rb8_mode1_a: assert property (
        stopEv[g] && s.ch[g].mode == UAFC_UART8 && s.ch[g].rxDlv
        && !acceptEv[g] && !(regWr && regAddr == OFS_CTRL[g])
        |=> s.ch[g].rb8 == $past(!stopBad[g]))
        else $error("mode 1 stop bit not captured");
      accept_c: cover property (acceptEv[g] && s.ch[g].sm2);
      fe_c: cover property ($rose(s.ch[g].fe));
      tx_c: cover property ($rose(s.ch[g].ti));
      mode0_c: cover property (dlvEv[g] && s.ch[g].mode == UAFC_SHIFT);
    end
  endgenerate

endmodule // uafc_top

`default_nettype wire

// File: dv/uafc_remote_node.sv
// uafc_remote_node: far-end UART node that drives one receive line
// assumes one 16x oversample tick every two clocks at the receiver
`default_nettype none

module uafc_remote_node (
  input  wire logic clock,
  output logic      line,
  output logic      rxTick,
  output logic      shiftTick,
  output logic      inStop
);
  timeunit 1ns;
  timeprecision 1ps;

  logic div;

  initial begin
    line = 1'b1;
    rxTick = 1'b0;
    shiftTick = 1'b0;
    inStop = 1'b0;
    div = 1'b0;
  end

  // the baud tick runs free, frames or not
  always @(posedge clock) begin
    div <= ~div;
    rxTick <= div;
  end

  // one bit is 16 ticks, 32 clocks
  task automatic bitOut(input logic b);
    line <= b;
    repeat (32) @(posedge clock);
  endtask

  task automatic send(input logic [7:0] d, input logic nine,
                      input logic use9, input logic stop);
    bitOut(1'b0);
    for (int i = 0; i < 8; i++) bitOut(d[i]);
    if (use9) bitOut(nine);
    inStop <= 1'b1;
    bitOut(stop);
    inStop <= 1'b0;
    // line is pulled up between frames
    bitOut(1'b1);
  endtask

  task automatic shift8(input logic [7:0] d);
    for (int i = 0; i < 8; i++) begin
      line <= d[i];
      repeat (4) @(posedge clock);
      shiftTick <= 1'b1;
      @(posedge clock);
      shiftTick <= 1'b0;
    end
    line <= 1'b1;
  endtask

endmodule // uafc_remote_node

`default_nettype wire

// File: dv/test_uart_frame_check_address_filter.sv
// test_uart_frame_check_address_filter: register-level bench of uafc_top
// assumes two remote nodes on the receive lines; transmit side idle
`default_nettype none

module test_uart_frame_check_address_filter import uafc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  logic       clock;
  logic       rst_n;
  logic [7:0] regAddr;
  logic [7:0] regWrData;
  logic       regWr;
  logic       regRd;
  logic [7:0] regRdData;
  logic       irq;
  wire  [1:0] rxd;
  wire  [1:0] txd;
  wire  [1:0] rxTick;
  wire  [1:0] shiftTick;
  wire  [1:0] inStop;
  int         errors;
  int         checks;
  int         k;
  logic [7:0] v;
  logic [7:0] cv [2];
  logic [7:0] rl [5] = '{8'hA9, 8'hB9, 8'hAA, 8'hBA, 8'h10};
  logic [7:0] tMask [8] = '{8'hFC, 8'hFC, 8'hFC, 8'hFC, 8'hFC, 8'hFF,
                            8'hFF, 8'hFF};
  logic [7:0] tAddr [8] = '{8'h55, 8'h5A, 8'hFE, 8'hFF, 8'h55, 8'h56,
                            8'h57, 8'hFF};
  logic       tNine [8] = '{1, 1, 1, 1, 0, 1, 1, 1};
  logic       tExp  [8] = '{1, 0, 1, 1, 0, 1, 0, 1};

  uafc_top uafc_top_inst (
    .clock     (clock),
    .rst_n     (rst_n),
    .regAddr   (regAddr),
    .regWrData (regWrData),
    .regWr     (regWr),
    .regRd     (regRd),
    .regRdData (regRdData),
    .rxdPin    (rxd),
    .txdPin    (txd),
    .rxTick    (rxTick),
    .txTick    (2'b00),
    .shiftTick (shiftTick),
    .irq       (irq)
  );

  uafc_remote_node uafc_remote_node_inst [1:0] (
    .clock     (clock),
    .line      (rxd),
    .rxTick    (rxTick),
    .shiftTick (shiftTick),
    .inStop    (inStop)
  );

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: read %h, want %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge clock);
    regWr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clock);
    regRd <= 1'b0;
    #1 d = regRdData;
  endtask

  task automatic summarize();
    if (errors == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic frame(input bit ch, input logic [7:0] d,
                       input logic nine, input logic use9, input logic s);
    if (ch) uafc_remote_node_inst[1].send(d, nine, use9, s);
    else uafc_remote_node_inst[0].send(d, nine, use9, s);
  endtask

  // reads flag and, when a frame is expected, data, then clears the flag with the held control
  task automatic rxCheck(input bit ch, input logic exp,
                         input logic [7:0] d);
    logic [7:0] c;
    rd(OFS_CTRL[ch], c);
    chk({7'h00, c[CTRL_RI]}, {7'h00, exp});
    if (exp) begin
      rd(OFS_DATA[ch], c);
      chk(c, d);
    end
    wr(OFS_CTRL[ch], cv[ch]);
  endtask

  task automatic irqIs(input logic exp);
    repeat (2) @(posedge clock);
    #1 chk({7'h00, irq}, {7'h00, exp});
  endtask

  initial begin
    rst_n = 1'b0;
    regAddr = 8'h00;
    regWrData = 8'h00;
    regWr = 1'b0;
    regRd = 1'b0;
    errors = 0;
    checks = 0;
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    foreach (rl[i]) begin
      rd(rl[i], v);
      chk(v, 8'h00);
    end
    chk({6'h00, txd}, 8'h03);
    irqIs(1'b0);
    cv[0] = 8'hF0;
    wr(8'h98, cv[0]);
    frame(0, 8'h37, 1, 1, 1);
    rxCheck(0, 1, 8'h37);
    wr(8'hA9, 8'h56);
    foreach (tAddr[i]) begin
      wr(8'hB9, tMask[i]);
      frame(0, tAddr[i], tNine[i], 1, 1);
      rxCheck(0, tExp[i], tAddr[i]);
    end
    cv[0] = 8'h30;
    wr(8'h98, cv[0]);
    uafc_remote_node_inst[0].shift8(8'hA5);
    rxCheck(0, 1, 8'hA5);
    cv[0] = 8'hD0;
    wr(8'h98, cv[0]);
    for (int n = 0; n < 2; n++) begin
      frame(0, 8'hA3, n[0], 1, 1);
      rd(8'h98, v);
      chk({7'h00, v[CTRL_RB8]}, {7'h00, n[0]});
      wr(8'h98, cv[0]);
    end
    for (int f = 0; f < 2; f++) begin
      wr(8'h87, f ? 8'h40 : 8'h00);
      fork
        frame(0, 8'h3C, 1, 1, 1);
        begin
          for (k = 0; k < 400 && inStop[0] !== 1'b1; k++)
            @(posedge clock);
          chk({7'h00, inStop[0]}, 8'h01);
          repeat (6) @(posedge clock);
          rd(8'h98, v);
          chk({7'h00, v[CTRL_RI]}, {7'h00, f == 0});
        end
      join
      wr(8'h87, 8'h00);
      wr(8'h98, cv[0]);
    end
    wr(OFS_IRQ_MASK, 8'h04);
    wr(8'h87, 8'h40);
    frame(0, 8'h5A, 1, 1, 0);
    rd(8'h98, v);
    chk({7'h00, v[7]}, 8'h01);
    irqIs(1'b1);
    // writing b7 high here keeps the error while clearing the flag
    wr(8'h98, cv[0]);
    frame(0, 8'h5B, 1, 1, 1);
    rd(8'h98, v);
    chk({7'h00, v[7]}, 8'h01);
    wr(8'h98, 8'h50);
    rd(8'h98, v);
    chk({7'h00, v[7]}, 8'h00);
    irqIs(1'b1);
    wr(OFS_IRQ_MASK, 8'h00);
    irqIs(1'b0);
    wr(OFS_IRQ_STAT, 8'h04);
    wr(OFS_IRQ_MASK, 8'h04);
    irqIs(1'b0);
    wr(8'h87, 8'h00);
    cv[0] = 8'h70;
    wr(8'h98, cv[0]);
    frame(0, 8'h56, 0, 0, 0);
    rxCheck(0, 0, 8'h56);
    frame(0, 8'h56, 0, 0, 1);
    rxCheck(0, 1, 8'h56);
    cv[1] = 8'hF0;
    wr(8'hC0, cv[1]);
    wr(8'hAA, 8'h33);
    wr(8'hBA, 8'hFF);
    frame(1, 8'h33, 1, 1, 1);
    rxCheck(1, 1, 8'h33);
    frame(1, 8'h34, 1, 1, 1);
    rxCheck(1, 0, 8'h34);
    summarize();
  end

endmodule // test_uart_frame_check_address_filter

`default_nettype wire
